// [src/msc_stat_counters.sv]
// APB statistics counter bank: clear-on-read event counters with warning interrupt.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "msc_params.svh"

// Functional notes
// - A counter read returns its value and clears the counter to zero.
// - Hardware adds one to a counter for each reported event.
// - Widths are chosen so no counter wraps in under 15 ms.
// - Errored packet counter at 60h: 16 bits, top 8 warn.
// - CRC error counter at 64h: 8 bits, top 4 warn.
// - CRC error: bad check value with an even nibble count.
// - Missed packet counter at 68h: 8 bits, counts FIFO overrun aborts.
// - Alignment error counter at 6Ch: 8 bits, top 4 warn.
// - Alignment error: bad check value with an odd nibble count.
// - Symbol error counter at 70h: 8 bits, once per packet.
// - Symbol error: receive error seen while receive data valid is high.
// - Overlength counter at 74h: 4 bits, frames above 1518 bytes.
// - Heartbeat loss counter at 78h: 4 bits, top 2 warn.
// - Warning flag is high while any counter is at its warning level.
// - Freeze holds all counters and ignores events; here a clearing read or clear-all write still zeroes a frozen counter.
// - Clear-all write zeroes every counter; reads back zero.
// - Test strobe write adds one to every enabled counter; reads zero.
module msc_stat_counters
    import msc_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [`MSC_AW-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic IRQ_O,
    input wire logic EV_ERRORED_I,
    input wire logic EV_MISSED_I,
    input wire logic EV_HB_LOSS_I,
    input wire logic RX_FRAME_END_I,
    input wire logic RX_CRC_BAD_I,
    input wire logic RX_ODD_NIBBLE_I,
    input wire logic [15:0] RX_LEN_I,
    input wire logic RX_DV_I,
    input wire logic RX_ER_I
);

    localparam int NC = `MSC_NCNT;
    localparam logic [31:0] CTL_RST = `MSC_CTL_RESET;

    // Index order: errored, crc, missed, alignment, symbol, overlength, heartbeat.
    localparam logic [NC-1:0][`MSC_AW-1:0] COFF = {
        `MSC_OFF_HB, `MSC_OFF_LONG, `MSC_OFF_SYM, `MSC_OFF_ALGN,
        `MSC_OFF_MISS, `MSC_OFF_CRC, `MSC_OFF_ERR
    };

    // Widths are kept as masks; each is sized so its count cannot wrap inside 15 ms.
    localparam msc_cnt_t CMASK = {
        `MSC_M_HB, `MSC_M_LONG, `MSC_M_SYM, `MSC_M_ALGN,
        `MSC_M_MISS, `MSC_M_CRC, `MSC_M_ERR
    };

    localparam msc_cnt_t WMASK = {
        `MSC_WM_HB, `MSC_WM_LONG, `MSC_WM_SYM, `MSC_WM_ALGN,
        `MSC_WM_MISS, `MSC_WM_CRC, `MSC_WM_ERR
    };

    localparam msc_state_t ST_RST = '{freeze: CTL_RST[`MSC_CTL_FRZ], default: '0};

    msc_state_t q;
    msc_state_t d;
    logic [NC-1:0] ev;
    logic [NC-1:0] inc_v;
    logic [NC-1:0] rd_hit;
    logic [NC-1:0] warn;
    logic cap;
    logic wr_done;
    logic wr_ctl;
    logic clr_all;
    logic strobe;
    logic mapped;

    always_comb
    begin
        d = q;
        inc_v = '0;
        rd_hit = '0;
        mapped = 1'b0;

        // A read is answered one cycle after the access phase starts.
        cap = PSEL_I & PENABLE_I & ~q.ready;
        wr_done = PSEL_I & PENABLE_I & q.ready & PWRITE_I;
        wr_ctl = wr_done & (PADDR_I == `MSC_OFF_CTL);
        clr_all = wr_ctl & PWDATA_I[`MSC_CTL_COUNTER_CLEAR_ALL];
        strobe = wr_ctl & PWDATA_I[`MSC_CTL_STRB];

        for (int i = 0; i < NC; i++)
        begin
            warn[i] = (q.cnt[i] & WMASK[i]) == WMASK[i];
        end

        ev[0] = EV_ERRORED_I;
        ev[1] = RX_FRAME_END_I & RX_CRC_BAD_I & ~RX_ODD_NIBBLE_I;
        ev[2] = EV_MISSED_I;
        ev[3] = RX_FRAME_END_I & RX_CRC_BAD_I & RX_ODD_NIBBLE_I;
        ev[4] = q.dv & ~RX_DV_I & q.sym;
        ev[5] = RX_FRAME_END_I & (RX_LEN_I > `MSC_MAX_FRAME);
        ev[6] = EV_HB_LOSS_I;

        // One error seen anywhere in the frame marks it; counted as the frame ends.
        d.dv = RX_DV_I;
        d.sym = RX_DV_I ? (q.sym | RX_ER_I) : 1'b0;

        d.ready = cap;
        d.err = 1'b0;
        if (cap)
        begin
            d.rdata = '0;
            for (int i = 0; i < NC; i++)
            begin
                if (PADDR_I == COFF[i])
                begin
                    mapped = 1'b1;
                    d.rdata = {16'h0, q.cnt[i]};
                    rd_hit[i] = ~PWRITE_I;
                end
            end
            if (PADDR_I == `MSC_OFF_CTL)
            begin
                mapped = 1'b1;
                d.rdata = {30'h0, q.freeze, |warn};
            end
            if (PADDR_I == `MSC_OFF_IST)
            begin
                mapped = 1'b1;
                d.rdata = {25'h0, q.ist};
            end
            if (PADDR_I == `MSC_OFF_IMSK)
            begin
                mapped = 1'b1;
                d.rdata = {25'h0, q.imask};
            end
            d.err = ~mapped;
        end

        if (wr_ctl)
        begin
            d.freeze = PWDATA_I[`MSC_CTL_FRZ];
        end
        if (wr_done & (PADDR_I == `MSC_OFF_IMSK))
        begin
            d.imask = PWDATA_I[NC-1:0];
        end

        for (int i = 0; i < NC; i++)
        begin
            inc_v[i] = (ev[i] | strobe) & ~q.freeze;
            if (clr_all)
            begin
                d.cnt[i] = '0;
            end
            else if (inc_v[i])
            begin
                // Clearing read and event together leave one, so no event is lost.
                d.cnt[i] = ((rd_hit[i] ? 16'h0 : q.cnt[i]) + 16'h1) & CMASK[i];
            end
            else if (rd_hit[i])
            begin
                d.cnt[i] = '0;
            end
        end

        // Warnings are re-asserted every cycle, so a clear cannot hide a live one.
        if (wr_done & (PADDR_I == `MSC_OFF_IST))
        begin
            d.ist = (q.ist & ~PWDATA_I[NC-1:0]) | warn;
        end
        else
        begin
            d.ist = q.ist | warn;
        end
        d.irq = |(d.ist & d.imask);
    end

    always_ff @(posedge MCLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            q <= ST_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign PRDATA_O = q.rdata;
    assign PREADY_O = q.ready;
    assign PSLVERR_O = q.err;
    assign IRQ_O = q.irq;

    a_read_clear: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        rd_hit[0] && !inc_v[0] && !clr_all |=> q.cnt[0] == 16'h0)
        else $error("counter not cleared by read");

    a_read_value: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        rd_hit[2] |=> PRDATA_O == {16'h0, $past(q.cnt[2])} && PREADY_O)
        else $error("read returned wrong value");

    a_read_event: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        rd_hit[1] && inc_v[1] && !clr_all |=> q.cnt[1] == 16'h1)
        else $error("event lost during clearing read");

    a_event_incr: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        inc_v[0] && !rd_hit[0] && !clr_all |=> q.cnt[0] == 16'($past(q.cnt[0]) + 16'h1))
        else $error("errored counter did not step");

    a_freeze_hold: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        q.freeze && rd_hit == '0 && !clr_all |=> $stable(q.cnt))
        else $error("frozen counters moved");

    a_clear_all: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        clr_all |=> q.cnt == '0 ##1 (!PSEL_I || PRDATA_O[`MSC_CTL_COUNTER_CLEAR_ALL] == 1'b0))
        else $error("clear-all failed");

    a_strobe_step: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        strobe && !q.freeze && !rd_hit[6] && !clr_all
        |=> q.cnt[6] == (16'($past(q.cnt[6]) + 16'h1) & 16'h000f))
        else $error("test strobe did not step");

    a_crc_even: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        RX_FRAME_END_I && RX_CRC_BAD_I && !RX_ODD_NIBBLE_I && !q.freeze |-> inc_v[1] && !ev[3])
        else $error("crc error not counted");

    a_align_odd: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        RX_FRAME_END_I && RX_CRC_BAD_I && RX_ODD_NIBBLE_I && !q.freeze |-> inc_v[3] && !ev[1])
        else $error("alignment error not counted");

    a_symbol_once: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        RX_DV_I && RX_ER_I ##1 RX_DV_I [*1] ##1 !RX_DV_I |-> ev[4])
        else $error("symbol error frame not counted");

    a_long_frame: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        RX_FRAME_END_I && RX_LEN_I == 16'h05ef |-> ev[5])
        else $error("overlength frame not counted");

    a_hb_width: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        q.cnt[6][15:4] == 12'h0 && q.cnt[5][15:4] == 12'h0)
        else $error("short counter exceeded width");

    a_warn_sets: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        q.cnt[5][3:2] == 2'b11 |=> q.ist[5])
        else $error("warning did not set status");

    a_warn_read: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        cap && !PWRITE_I && PADDR_I == `MSC_OFF_CTL |=> PRDATA_O[`MSC_CTL_WRN] == $past(|warn))
        else $error("warning flag wrong");

    a_ready_pulse: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        PREADY_O |=> !PREADY_O)
        else $error("ready held longer than one cycle");

    a_ready_follows: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        cap |=> PREADY_O)
        else $error("access not answered");

    a_error_ready: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        PSLVERR_O |-> PREADY_O)
        else $error("error response without ready");

    a_error_data_zero: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        PSLVERR_O |-> PRDATA_O == 32'h0)
        else $error("unmapped read returned data");

    a_errored_read_value: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        rd_hit[0] |=> PRDATA_O == {16'h0, $past(q.cnt[0])})
        else $error("errored counter read wrong");

    a_crc_read_value: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        rd_hit[1] |=> PRDATA_O == {16'h0, $past(q.cnt[1])})
        else $error("crc counter read wrong");

    a_align_read_value: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        rd_hit[3] |=> PRDATA_O == {16'h0, $past(q.cnt[3])})
        else $error("alignment counter read wrong");

    a_sym_read_value: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        rd_hit[4] |=> PRDATA_O == {16'h0, $past(q.cnt[4])})
        else $error("symbol counter read wrong");

    a_long_read_value: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        rd_hit[5] |=> PRDATA_O == {16'h0, $past(q.cnt[5])})
        else $error("overlength counter read wrong");

    a_hb_read_value: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        rd_hit[6] |=> PRDATA_O == {16'h0, $past(q.cnt[6])})
        else $error("heartbeat counter read wrong");

    a_crc_incr: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        inc_v[1] && !rd_hit[1] && !clr_all
        |=> q.cnt[1] == (16'($past(q.cnt[1]) + 16'h1) & 16'h00ff))
        else $error("crc counter did not step");

    a_miss_incr: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        inc_v[2] && !rd_hit[2] && !clr_all
        |=> q.cnt[2] == (16'($past(q.cnt[2]) + 16'h1) & 16'h00ff))
        else $error("missed counter did not step");

    a_align_incr: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        inc_v[3] && !rd_hit[3] && !clr_all
        |=> q.cnt[3] == (16'($past(q.cnt[3]) + 16'h1) & 16'h00ff))
        else $error("alignment counter did not step");

    a_sym_incr: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        inc_v[4] && !rd_hit[4] && !clr_all
        |=> q.cnt[4] == (16'($past(q.cnt[4]) + 16'h1) & 16'h00ff))
        else $error("symbol counter did not step");

    a_long_incr: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        inc_v[5] && !rd_hit[5] && !clr_all
        |=> q.cnt[5] == (16'($past(q.cnt[5]) + 16'h1) & 16'h000f))
        else $error("overlength counter did not step");

    a_hb_incr: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        inc_v[6] && !rd_hit[6] && !clr_all
        |=> q.cnt[6] == (16'($past(q.cnt[6]) + 16'h1) & 16'h000f))
        else $error("heartbeat counter did not step");

    a_byte_width: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        q.cnt[1][15:8] == 8'h0 && q.cnt[2][15:8] == 8'h0 &&
        q.cnt[3][15:8] == 8'h0 && q.cnt[4][15:8] == 8'h0)
        else $error("byte counter exceeded width");

    a_errored_event: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        EV_ERRORED_I && !q.freeze |-> inc_v[0])
        else $error("errored packet not counted");

    a_miss_event: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        EV_MISSED_I && !q.freeze |-> inc_v[2])
        else $error("missed packet not counted");

    a_hb_event: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        EV_HB_LOSS_I && !q.freeze |-> inc_v[6])
        else $error("heartbeat loss not counted");

    a_short_frame: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        RX_FRAME_END_I && RX_LEN_I <= 16'h05ee |-> !ev[5])
        else $error("legal frame counted as overlength");

    a_frame_qualify: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        !RX_FRAME_END_I |-> !ev[1] && !ev[3] && !ev[5])
        else $error("frame error counted outside frame end");

    a_freeze_ignore: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        q.freeze |-> inc_v == '0)
        else $error("event taken while frozen");

    a_strobe_all: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        strobe && !q.freeze |-> inc_v == '1)
        else $error("test strobe missed a counter");

    a_ctl_reads_zero: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        cap && !PWRITE_I && PADDR_I == `MSC_OFF_CTL |=> PRDATA_O[3:2] == 2'b00)
        else $error("write-only control bits read back set");

    a_irq_level: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        IRQ_O == |(q.ist & q.imask))
        else $error("interrupt level wrong");

    a_status_sticky: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        q.ist[0] && !(wr_done && PADDR_I == `MSC_OFF_IST) |=> q.ist[0])
        else $error("status bit lost without clear");

    a_freeze_write: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        wr_ctl |=> q.freeze == $past(PWDATA_I[`MSC_CTL_FRZ]))
        else $error("freeze bit not written");

    a_sym_frame_end: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        ev[4] |-> !RX_DV_I && q.dv)
        else $error("symbol error counted inside frame");

endmodule // msc_stat_counters

// [src/msc_params.svh]
// Register offsets, field positions, reset values and widths of the statistics counters.
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH

`define MSC_NCNT 7
`define MSC_AW 8

`define MSC_OFF_CTL 8'h5c
`define MSC_OFF_IST 8'h40
`define MSC_OFF_IMSK 8'h44
`define MSC_OFF_ERR 8'h60
`define MSC_OFF_CRC 8'h64
`define MSC_OFF_MISS 8'h68
`define MSC_OFF_ALGN 8'h6c
`define MSC_OFF_SYM 8'h70
`define MSC_OFF_LONG 8'h74
`define MSC_OFF_HB 8'h78

`define MSC_CTL_RESET 32'h00000002
`define MSC_CTL_WRN 0
`define MSC_CTL_FRZ 1
`define MSC_CTL_COUNTER_CLEAR_ALL 2
`define MSC_CTL_STRB 3

`define MSC_W_ERR 16
`define MSC_W_CRC 8
`define MSC_W_MISS 8
`define MSC_W_ALGN 8
`define MSC_W_SYM 8
`define MSC_W_LONG 4
`define MSC_W_HB 4
`define MSC_W_MAX 16

`define MSC_M_ERR 16'hffff
`define MSC_M_CRC 16'h00ff
`define MSC_M_MISS 16'h00ff
`define MSC_M_ALGN 16'h00ff
`define MSC_M_SYM 16'h00ff
`define MSC_M_LONG 16'h000f
`define MSC_M_HB 16'h000f

`define MSC_WM_ERR 16'hff00
`define MSC_WM_CRC 16'h00f0
`define MSC_WM_MISS 16'h00f0
`define MSC_WM_ALGN 16'h00f0
`define MSC_WM_SYM 16'h00f0
`define MSC_WM_LONG 16'h000c
`define MSC_WM_HB 16'h000c

`define MSC_MAX_FRAME 16'h05ee

`endif

// [src/msc_pkg.sv]
// Types shared by the statistics counter bank.
package msc_pkg;
`include "msc_params.svh"

    typedef logic [`MSC_NCNT-1:0][`MSC_W_MAX-1:0] msc_cnt_t;

    typedef struct packed {
        msc_cnt_t cnt;
        logic freeze;
        logic [`MSC_NCNT-1:0] ist;
        logic [`MSC_NCNT-1:0] imask;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic irq;
        logic dv;
        logic sym;
    } msc_state_t;
endpackage

// [tb/msc_mac_model.sv]
// Behavioural model of the MAC receive and transmit event logic.
`timescale 1ns/1ps
module msc_mac_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [2:0] kind_i,
    output logic ev_err_o = 1'b0,
    output logic ev_miss_o = 1'b0,
    output logic ev_hb_o = 1'b0,
    output logic fend_o = 1'b0,
    output logic crc_bad_o = 1'b0,
    output logic odd_o = 1'b0,
    output logic [15:0] len_o = 16'h0000,
    output logic dv_o = 1'b0,
    output logic er_o = 1'b0
);
    logic frame;
    assign frame = go_i && (kind_i == 3'h1 || kind_i == 3'h3 || kind_i == 3'h5);
    always_ff @(posedge clk_i)
    begin
        ev_err_o <= go_i && kind_i == 3'h0;
        ev_miss_o <= go_i && kind_i == 3'h2;
        ev_hb_o <= go_i && kind_i == 3'h6;
        fend_o <= frame;
        crc_bad_o <= go_i && (kind_i == 3'h1 || kind_i == 3'h3);
        odd_o <= go_i && kind_i == 3'h3;
        // Length is only meaningful with the frame end, so it toggles otherwise.
        len_o <= !frame ? ~len_o : (kind_i == 3'h5 ? 16'h05ef : 16'h0040);
        // One receive error inside a two-cycle valid window.
        er_o <= go_i && kind_i == 3'h4;
        dv_o <= (go_i && kind_i == 3'h4) || er_o;
    end
endmodule // msc_mac_model

// [tb/msc_stat_counters_bench.sv]
// Self-checking bench of the statistics counter bank.
`timescale 1ns/1ps
module msc_stat_counters_bench;
    typedef struct packed {logic [2:0] kind; logic [7:0] n; logic [7:0] addr; logic [15:0] exp;} msc_row_t;
    msc_row_t rows [7] = '{'{3'h0, 8'h03, 8'h60, 16'h0003}, '{3'h1, 8'h02, 8'h64, 16'h0002},
        '{3'h2, 8'h01, 8'h68, 16'h0001}, '{3'h3, 8'h02, 8'h6c, 16'h0002},
        '{3'h4, 8'h02, 8'h70, 16'h0002}, '{3'h5, 8'h01, 8'h74, 16'h0001},
        '{3'h6, 8'h11, 8'h78, 16'h0001}};
    logic clk, rst, psel, pen, pwr, pready, pslverr, irq, go, serr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] kind;
    logic ev_err, ev_miss, ev_hb, fend, bad, odd, dv, er;
    logic [15:0] len;
    int err_count = 0;
    int n_checks = 0;
    msc_stat_counters msc_stat_counters_inst (.MCLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq), .EV_ERRORED_I(ev_err),
        .EV_MISSED_I(ev_miss), .EV_HB_LOSS_I(ev_hb), .RX_FRAME_END_I(fend), .RX_CRC_BAD_I(bad),
        .RX_ODD_NIBBLE_I(odd), .RX_LEN_I(len), .RX_DV_I(dv), .RX_ER_I(er));
    msc_mac_model msc_mac_model_inst (.clk_i(clk), .go_i(go), .kind_i(kind), .ev_err_o(ev_err),
        .ev_miss_o(ev_miss), .ev_hb_o(ev_hb), .fend_o(fend), .crc_bad_o(bad), .odd_o(odd),
        .len_o(len), .dv_o(dv), .er_o(er));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0; pen <= 1'b0;
    endtask
    task automatic fire(input logic [2:0] k, input logic [7:0] n);
        repeat (n)
        begin
            @(posedge clk);
            go <= 1'b1; kind <= k;
            @(posedge clk);
            go <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_of_test;
    end
    initial
    begin
        rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        go = 1'b0; kind = 3'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, 8'h5c, 32'h0); chk(rd, 32'h00000002);
        fire(3'h0, 8'h02);
        apb(1'b0, 8'h60, 32'h0); chk(rd, 32'h0);
        apb(1'b1, 8'h5c, 32'h0);
        // Each counter in turn, then a second read to see the clear.
        foreach (rows[i])
        begin
            fire(rows[i].kind, rows[i].n);
            apb(1'b0, rows[i].addr, 32'h0); chk(rd, {16'h0, rows[i].exp});
            apb(1'b0, rows[i].addr, 32'h0); chk(rd, 32'h0);
        end
        apb(1'b1, 8'h44, 32'h0);
        // The heartbeat wrap above left a sticky warning; clear all status first.
        apb(1'b1, 8'h40, 32'h7f);
        fire(3'h5, 8'h0c);
        apb(1'b0, 8'h40, 32'h0); chk(rd, 32'h00000020);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 8'h44, 32'h20);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, 8'h5c, 32'h0); chk(rd, 32'h00000001);
        apb(1'b0, 8'h74, 32'h0); chk(rd, 32'h0000000c);
        apb(1'b0, 8'h5c, 32'h0); chk(rd, 32'h0);
        apb(1'b1, 8'h40, 32'h20);
        apb(1'b0, 8'h40, 32'h0); chk(rd, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        fire(3'h1, 8'h01);
        apb(1'b1, 8'h5c, 32'h4);
        apb(1'b0, 8'h64, 32'h0); chk(rd, 32'h0);
        apb(1'b0, 8'h60, 32'h0); chk(rd, 32'h0);
        apb(1'b1, 8'h5c, 32'h8);
        apb(1'b0, 8'h5c, 32'h0); chk(rd, 32'h0);
        apb(1'b0, 8'h60, 32'h0); chk(rd, 32'h1);
        apb(1'b0, 8'h78, 32'h0); chk(rd, 32'h1);
        // The crc event reaches the counter in the very cycle of the clearing read.
        fork
            apb(1'b0, 8'h64, 32'h0);
            fire(3'h1, 8'h01);
        join
        chk(rd, 32'h1);
        apb(1'b0, 8'h64, 32'h0); chk(rd, 32'h1);
        apb(1'b0, 8'h10, 32'h0); chk({serr, rd[30:0]}, 32'h80000000);
        fire(3'h6, 8'h01);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 8'h5c, 32'h0); chk(rd, 32'h00000002);
        apb(1'b0, 8'h78, 32'h0); chk(rd, 32'h0);
        end_of_test;
    end
endmodule // msc_stat_counters_bench
